// [core/opdec_defs.svh]
/*
  constants for the opcode map decoder: column digits, stack column digits and
  the prefix byte. assumes nothing of its surroundings; included by name.
*/
`ifndef OPDEC_DEFS_SVH
`define OPDEC_DEFS_SVH

// ----------------------------------------------------------------------
// prefix byte and the column digits behind it
// ----------------------------------------------------------------------
`define OPDEC_PREFIX_BYTE 8'h9E
`define OPDEC_SP_COL_RMW 4'h6
`define OPDEC_SP_COL_IX2 4'hD
`define OPDEC_SP_COL_IX1 4'hE

// ----------------------------------------------------------------------
// column digits
// ----------------------------------------------------------------------
`define OPDEC_COL_BRANCH 4'h2
`define OPDEC_COL_RMW_DIR 4'h3
`define OPDEC_COL_RMW_A 4'h4
`define OPDEC_COL_RMW_X 4'h5
`define OPDEC_COL_RMW_IX1 4'h6
`define OPDEC_COL_RMW_IX 4'h7
`define OPDEC_COL_CTRL0 4'h8
`define OPDEC_COL_CTRL1 4'h9
`define OPDEC_COL_IMM 4'hA
`define OPDEC_COL_DIR 4'hB
`define OPDEC_COL_EXT 4'hC
`define OPDEC_COL_IX2 4'hD
`define OPDEC_COL_IX1 4'hE
`define OPDEC_COL_IX 4'hF

`endif

// [core/opdec_pkg.sv]
/*
  types for the opcode map decoder: instruction groups and operand modes.
  assumes the constants header is included by the decoder itself.
*/
package opdec_pkg;

  // ----------------------------------------------------------------------
  // instruction groups by column
  // ----------------------------------------------------------------------
  typedef enum logic [2:0] {
    opdec_grp_bit_type = 3'b000,
    opdec_grp_branch_type = 3'b001,
    opdec_grp_rmw_type = 3'b010,
    opdec_grp_ctrl_type = 3'b011,
    opdec_grp_regmem_type = 3'b100
  } opdec_group_type;

  // ----------------------------------------------------------------------
  // operand modes
  // ----------------------------------------------------------------------
  typedef enum logic [3:0] {
    implied_operand_mode = 4'b0000,
    relative_mode = 4'b0001,
    literal_operand_mode = 4'b0010,
    index_no_offset_mode = 4'b0011,
    page_mode = 4'b0100,
    extended_mode = 4'b0101,
    index_short_offset_mode = 4'b0110,
    index_long_offset_mode = 4'b0111,
    stack_short_offset_mode = 4'b1000,
    stack_long_offset_mode = 4'b1001,
    index_postinc_mode = 4'b1010,
    index_offset_postinc_mode = 4'b1011,
    page_to_page_move = 4'b1100,
    literal_to_page_move = 4'b1101,
    postinc_to_page_move = 4'b1110,
    page_to_postinc_move = 4'b1111
  } opdec_mode_type;

  // prefix tracking states
  typedef enum logic [0:0] {
    opdec_st_plain = 1'b0,
    opdec_st_prefixed = 1'b1
  } opdec_state_type;

endpackage : opdec_pkg

// [core/opdec_decoder.sv]
/*
  opcode map decoder: takes one fetched byte per strobe, tracks the stack
  prefix byte and registers group, mode, prefix flag and illegal flag.
  assumes the fetch path presents bytes on core_clk with a one-cycle strobe
  and that operand bytes are not strobed in as opcodes.
*/
`timescale 1ns/1ns
`include "opdec_defs.svh"

// How it works
// - high digit picks the map column, low digit picks the row
// - prefix byte moves next opcode into stack columns 6, D and E
// - stack modes use 8-bit unsigned or 16-bit offset on stack pointer
// - post-increment index modes, with no offset or one-byte offset
// - four memory-to-memory move modes are recognised
// - basic modes: inherent, relative, immediate, index, direct, extended, offsets
// - columns grouped: bit, branch, read-modify-write, control, register/memory
module opdec_decoder
  import opdec_pkg::*;
(
  // clock, reset, enable
  input wire logic core_clk,
  input wire logic srst,
  input wire logic clk_en,
  // fetched byte
  input wire logic op_valid,
  input wire logic [7:0] op_byte,
  // decoded result
  output logic dec_valid,
  output opdec_group_type dec_group,
  output opdec_mode_type dec_mode,
  output logic dec_stack,
  output logic dec_illegal,
  output logic prefix_pending
);

  // ----------------------------------------------------------------------
  // state
  // ----------------------------------------------------------------------
  opdec_state_type state_r, state_nxt;
  logic valid_r, valid_nxt;
  opdec_group_type group_r, group_nxt;
  opdec_mode_type mode_r, mode_nxt;
  logic stack_r, stack_nxt;
  logic illegal_r, illegal_nxt;
  logic [3:0] col;
  logic [3:0] row;
  logic pre;
  logic blank;

  assign col = op_byte[7:4];
  assign row = op_byte[3:0];
  assign pre = (state_r == opdec_st_prefixed);

  // group by column digit; prefix keeps the group of the column it lands in
  function automatic opdec_group_type group_of(input logic [3:0] c);
    if (c <= 4'h1) begin
      group_of = opdec_grp_bit_type;
    end else if (c == `OPDEC_COL_BRANCH) begin
      group_of = opdec_grp_branch_type;
    end else if (c <= `OPDEC_COL_RMW_IX) begin
      group_of = opdec_grp_rmw_type;
    end else if (c <= `OPDEC_COL_CTRL1) begin
      group_of = opdec_grp_ctrl_type;
    end else begin
      group_of = opdec_grp_regmem_type;
    end
  endfunction : group_of

  // ----------------------------------------------------------------------
  // mode and blank-cell decode
  // ----------------------------------------------------------------------
  always_comb begin
    mode_nxt = implied_operand_mode;
    blank = 1'b0;
    if (pre) begin
      // only three columns exist behind the prefix
      case (col)
        `OPDEC_SP_COL_RMW: begin
          mode_nxt = stack_short_offset_mode;
          blank = (row == 4'h2) || (row == 4'h5) || (row == 4'hE);
        end
        `OPDEC_SP_COL_IX2: begin
          mode_nxt = stack_long_offset_mode;
          blank = (row == 4'h7) || (row == 4'hC) || (row == 4'hD);
        end
        `OPDEC_SP_COL_IX1: begin
          mode_nxt = stack_short_offset_mode;
          blank = (row == 4'hC) || (row == 4'hD);
        end
        default: begin
          blank = 1'b1;
        end
      endcase
    end else begin
      case (col)
        4'h0, 4'h1: begin
          mode_nxt = page_mode;
          blank = (col == 4'h0) ? (row >= 4'hC && row != 4'hF)
                                : (row == 4'h9 || row == 4'hC);
        end
        `OPDEC_COL_BRANCH: begin
          mode_nxt = relative_mode;
          blank = (row == 4'hD) || (row == 4'hE);
        end
        `OPDEC_COL_RMW_DIR: begin
          mode_nxt = page_mode;
          blank = (row == 4'h2) || (row == 4'hC) || (row == 4'hE);
        end
        `OPDEC_COL_RMW_A: begin
          // rows 1 and 5 carry an immediate operand in this column
          mode_nxt = (row == 4'h1 || row == 4'h5) ? literal_operand_mode :
                     (row == 4'hE) ? page_to_page_move : implied_operand_mode;
          blank = (row == 4'hD);
        end
        `OPDEC_COL_RMW_X: begin
          mode_nxt = (row == 4'h1) ? literal_operand_mode :
                     (row == 4'h5) ? page_mode :
                     (row == 4'hE) ? page_to_postinc_move : implied_operand_mode;
          blank = (row == 4'hD);
        end
        `OPDEC_COL_RMW_IX1: begin
          mode_nxt = (row == 4'h1) ? index_offset_postinc_mode :
                     (row == 4'h2) ? implied_operand_mode :
                     (row == 4'h5) ? literal_operand_mode :
                     (row == 4'hE) ? literal_to_page_move : index_short_offset_mode;
          blank = (row == 4'h4) || (row == 4'hC);
        end
        `OPDEC_COL_RMW_IX: begin
          mode_nxt = (row == 4'h1) ? index_postinc_mode :
                     (row == 4'h2) ? implied_operand_mode :
                     (row == 4'h5) ? page_mode :
                     (row == 4'hE) ? postinc_to_page_move : index_no_offset_mode;
          blank = (row == 4'hD);
        end
        `OPDEC_COL_CTRL0: begin
          mode_nxt = implied_operand_mode;
          blank = (row == 4'h2) || (row == 4'hD);
        end
        `OPDEC_COL_CTRL1: begin
          mode_nxt = (row <= 4'h3) ? relative_mode : implied_operand_mode;
          // 9E is the prefix itself and handled before this table
          blank = (row == 4'h6);
        end
        `OPDEC_COL_IMM: begin
          mode_nxt = (row == 4'hD) ? relative_mode : literal_operand_mode;
          blank = (row == 4'h7) || (row == 4'hC) || (row == 4'hE);
        end
        `OPDEC_COL_DIR: begin
          mode_nxt = page_mode;
          blank = 1'b0;
        end
        `OPDEC_COL_EXT: begin
          mode_nxt = extended_mode;
          blank = 1'b0;
        end
        `OPDEC_COL_IX2: begin
          mode_nxt = index_long_offset_mode;
          blank = 1'b0;
        end
        `OPDEC_COL_IX1: begin
          mode_nxt = index_short_offset_mode;
          blank = 1'b0;
        end
        default: begin
          mode_nxt = index_no_offset_mode;
          blank = 1'b0;
        end
      endcase
    end
    // mode holds between results so the output stays stable
    if (!valid_nxt) begin
      mode_nxt = mode_r;
    end
  end

  // ----------------------------------------------------------------------
  // prefix tracking and result registers
  // ----------------------------------------------------------------------
  always_comb begin
    state_nxt = state_r;
    valid_nxt = 1'b0;
    group_nxt = group_r;
    stack_nxt = stack_r;
    illegal_nxt = illegal_r;
    if (op_valid) begin
      if (!pre && op_byte == `OPDEC_PREFIX_BYTE) begin
        // prefix produces no result of its own; it waits for the opcode
        state_nxt = opdec_st_prefixed;
      end else begin
        state_nxt = opdec_st_plain;
        valid_nxt = 1'b1;
        group_nxt = group_of(col);
        stack_nxt = pre;
        illegal_nxt = blank;
      end
    end
  end

  // result registers; srst clears them even with the enable low, otherwise everything freezes while the enable is low
  always_ff @(posedge core_clk) begin
    if (srst) begin
      state_r <= opdec_st_plain;
      valid_r <= 1'b0;
      group_r <= opdec_grp_bit_type;
      mode_r <= implied_operand_mode;
      stack_r <= 1'b0;
      illegal_r <= 1'b0;
    end else if (clk_en) begin
      state_r <= state_nxt;
      valid_r <= valid_nxt;
      group_r <= group_nxt;
      mode_r <= mode_nxt;
      stack_r <= stack_nxt;
      illegal_r <= illegal_nxt;
    end
  end

  assign dec_valid = valid_r;
  assign dec_group = group_r;
  assign dec_mode = mode_r;
  assign dec_stack = stack_r;
  assign dec_illegal = illegal_r;
  assign prefix_pending = pre;

endmodule : opdec_decoder

// [testbench/opdec_fetch_model.sv]
/*
  fetch path model: strobes one byte per call on core_clk.
  assumes the bench calls push and idle back to back.
*/
`timescale 1ns/1ns
module opdec_fetch_model (
  // clock
  input wire logic core_clk,
  // byte strobe
  output logic op_valid,
  output logic [7:0] op_byte
);
  initial begin
    op_valid = 1'b0;
    op_byte = 8'h00;
  end
  // one-cycle strobe, launched just after an edge
  task push(input logic [7:0] b);
    @(posedge core_clk);
    #1;
    op_valid = 1'b1;
    op_byte = b;
  endtask : push
  // released byte lane shows the inverse, so stale data never looks valid
  task idle();
    @(posedge core_clk);
    #1;
    op_valid = 1'b0;
    op_byte = ~op_byte;
  endtask : idle
endmodule : opdec_fetch_model

// [testbench/opdec_decoder_props.sv]
/*
  checker for the opcode decoder, bound to its ports.
  assumes one clock and the synchronous reset srst.
*/
`timescale 1ns/1ns
`include "opdec_defs.svh"
module opdec_decoder_chk
  import opdec_pkg::*;
(
  // clock and reset
  input wire logic core_clk,
  input wire logic srst,
  input wire logic clk_en,
  // fetch side
  input wire logic op_valid,
  input wire logic [7:0] op_byte,
  // decoded side
  input wire logic dec_valid,
  input wire opdec_group_type dec_group,
  input wire opdec_mode_type dec_mode,
  input wire logic dec_stack,
  input wire logic dec_illegal,
  input wire logic prefix_pending
);
  default clocking cb @(posedge core_clk); endclocking
  default disable iff (srst);
  // a taken byte, and a taken unprefixed opcode
  logic take_w;
  logic plain_w;
  assign take_w = clk_en && op_valid;
  assign plain_w = take_w && !prefix_pending && op_byte != `OPDEC_PREFIX_BYTE;
  chk_plain_latency: assert property (plain_w |=> dec_valid && !dec_stack)
    else $error("opcode gave no result");
  chk_prefix_arms: assert property (
    take_w && !prefix_pending && op_byte == `OPDEC_PREFIX_BYTE |=> prefix_pending && !dec_valid)
    else $error("prefix byte not held");
  chk_prefix_used: assert property (
    take_w && prefix_pending |=> !prefix_pending && dec_valid && dec_stack)
    else $error("prefixed opcode wrong");
  chk_no_strobe: assert property (clk_en && !op_valid |=> !dec_valid)
    else $error("result without strobe");
  chk_branch_col: assert property (
    plain_w && op_byte[7:4] == 4'h2 |=> dec_group == opdec_grp_branch_type
      && dec_mode == relative_mode)
    else $error("branch column wrong");
  chk_regmem_col: assert property (
    plain_w && op_byte[7:4] >= 4'hA |=> dec_group == opdec_grp_regmem_type)
    else $error("register column wrong");
  chk_rmw_col: assert property (
    plain_w && op_byte[7:4] inside {[4'h3:4'h7]} |=> dec_group == opdec_grp_rmw_type)
    else $error("rmw column wrong");
  chk_bit_col: assert property (
    plain_w && op_byte[7:5] == 3'h0 |=> dec_group == opdec_grp_bit_type)
    else $error("bit column wrong");
  chk_stack_long: assert property (
    take_w && prefix_pending && op_byte[7:4] == 4'hD |=> dec_mode == stack_long_offset_mode)
    else $error("stack long mode wrong");
  chk_prefix_blank: assert property (
    take_w && prefix_pending && !(op_byte[7:4] inside {4'h6, 4'hD, 4'hE}) |=> dec_illegal)
    else $error("prefixed blank not flagged");
  chk_freeze_hold: assert property (
    !clk_en |=> $stable(prefix_pending) && $stable(dec_group) && $stable(dec_mode))
    else $error("state moved while frozen");
endmodule : opdec_decoder_chk
bind opdec_decoder opdec_decoder_chk u_chk (.core_clk(core_clk), .srst(srst),
  .clk_en(clk_en), .op_valid(op_valid), .op_byte(op_byte), .dec_valid(dec_valid),
  .dec_group(dec_group), .dec_mode(dec_mode), .dec_stack(dec_stack),
  .dec_illegal(dec_illegal), .prefix_pending(prefix_pending));

// [testbench/opdec_decoder_test.sv]
/*
  self-checking bench for the opcode decoder: mode table, blank cells,
  random single bytes and a random stream with clock-enable gaps.
  assumes the fetch model and the bound checker are compiled alongside.
*/
`timescale 1ns/1ns
module opdec_decoder_test;
  import opdec_pkg::*;
  logic core_clk = 1'b0;
  logic srst = 1'b1;
  logic clk_en = 1'b1;
  logic op_valid;
  logic [7:0] op_byte;
  logic dec_valid;
  opdec_group_type dec_group;
  opdec_mode_type dec_mode;
  logic dec_stack;
  logic dec_illegal;
  logic prefix_pending;
  int err_total = 0;
  int total_checks = 0;
  logic [7:0] b;
  // high byte 9e marks a prefixed form
  logic [15:0] t_op [0:18] = '{16'h00a6, 16'h00b6, 16'h00c6, 16'h00d6, 16'h00e6,
    16'h00f6, 16'h0020, 16'h0040, 16'h0071, 16'h0061, 16'h004e, 16'h006e, 16'h007e,
    16'h005e, 16'h9ee6, 16'h9ed6, 16'h9e60, 16'h0045, 16'h00ad};
  opdec_mode_type t_md [0:18] = '{literal_operand_mode, page_mode, extended_mode,
    index_long_offset_mode, index_short_offset_mode, index_no_offset_mode,
    relative_mode, implied_operand_mode, index_postinc_mode, index_offset_postinc_mode,
    page_to_page_move, literal_to_page_move, postinc_to_page_move,
    page_to_postinc_move, stack_short_offset_mode, stack_long_offset_mode,
    stack_short_offset_mode, literal_operand_mode, relative_mode};
  logic [15:0] t_bad [0:3] = '{16'h0032, 16'h0082, 16'h9e9e, 16'h9e65};
  always #25 core_clk = ~core_clk;
  opdec_fetch_model fm (.core_clk(core_clk), .op_valid(op_valid), .op_byte(op_byte));
  opdec_decoder dut (.core_clk(core_clk), .srst(srst), .clk_en(clk_en),
    .op_valid(op_valid), .op_byte(op_byte), .dec_valid(dec_valid),
    .dec_group(dec_group), .dec_mode(dec_mode), .dec_stack(dec_stack),
    .dec_illegal(dec_illegal), .prefix_pending(prefix_pending));
  // column digit sets the group
  function automatic opdec_group_type exp_group(input logic [7:0] v);
    case (v[7:4])
      4'h0, 4'h1: return opdec_grp_bit_type;
      4'h2: return opdec_grp_branch_type;
      4'h8, 4'h9: return opdec_grp_ctrl_type;
      default: return v[7:4] < 4'h8 ? opdec_grp_rmw_type : opdec_grp_regmem_type;
    endcase
  endfunction : exp_group
  task check(input logic [7:0] seen, input logic [7:0] exp, input string msg);
    total_checks++;
    if (seen !== exp) begin
      err_total++;
      $display("wrong value at %0t: %s got %h want %h", $time, msg, seen, exp);
    end
  endtask : check
  task wrap_up();
    $display("checks %0d, mismatches %0d", total_checks, err_total);
    if (err_total == 0 && total_checks > 0) $display("ALL TESTS PASSED");
    else $display("TESTS FAILED");
    $finish;
  endtask : wrap_up
  // sends one opcode, prefixed when asked, and leaves the result settled
  task send(input logic [15:0] w);
    if (w[15:8] == 8'h9e) begin
      fm.push(8'h9e);
      fm.push(w[7:0]);
      check(8'(prefix_pending), 8'h01, "pending");
    end else fm.push(w[7:0]);
    fm.idle();
    check(8'(dec_valid), 8'h01, "valid");
    check(8'(dec_stack), 8'(w[15:8] == 8'h9e), "stack");
    check(8'(dec_group), 8'(exp_group(w[7:0])), "group");
  endtask : send
  initial begin
    repeat (20000) @(posedge core_clk);
    err_total++;
    wrap_up();
  end
  initial begin
    void'($urandom(99));
    repeat (20) @(posedge core_clk);
    #1 srst = 1'b0;
    check(8'(dec_valid), 8'h00, "reset valid");
    check(8'(prefix_pending), 8'h00, "reset pending");
    check(8'(dec_illegal), 8'h00, "reset illegal");
    foreach (t_op[i]) begin
      send(t_op[i]);
      check(8'(dec_mode), 8'(t_md[i]), "mode");
      check(8'(dec_illegal), 8'h00, "legal");
    end
    foreach (t_bad[i]) begin
      send(t_bad[i]);
      check(8'(dec_illegal), 8'h01, "blank cell");
    end
    // reset while a prefix waits: the next byte must decode unprefixed
    fm.push(8'h9e);
    fm.idle();
    check(8'(prefix_pending), 8'h01, "armed");
    srst = 1'b1;
    repeat (2) @(posedge core_clk);
    #1 srst = 1'b0;
    check(8'(prefix_pending), 8'h00, "mid reset pending");
    send(16'h00e6);
    check(8'(dec_mode), 8'(index_short_offset_mode), "mode after reset");
    repeat (200) begin
      b = 8'($urandom);
      send({8'h00, (b == 8'h9e) ? 8'ha6 : b});
    end
    // back-to-back stream with enable gaps, judged by the checker
    repeat (300) begin
      fm.push(8'($urandom));
      clk_en = ($urandom % 4) != 0;
    end
    clk_en = 1'b1;
    fm.idle();
    wrap_up();
  end
endmodule : opdec_decoder_test
